/* File: logic/abc_conv_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module abc_conv_ctrl
  import abc_pkg::*;
#(
  parameter bit MULTI_SAMPLE = 1'b0
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       conv_clk,
  input  wire logic       chip_sel_n,
  input  wire logic       read_n,
  input  wire logic       mode,
  input  wire logic       comp_high,
  output logic            busy_n,
  output logic [7:0]      data_out,
  output logic [7:0]      data_oe_n,
  output logic            sample_switch,
  output logic [7:0]      dac_code
);

  // reset release through two flops
  logic rst_s1_q;
  logic rst_sync_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // pin synchronisers
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_s1_q <= 4'hf;
      pin_s2_q <= 4'hf;
    end else begin
      pin_s1_q <= {conv_clk, chip_sel_n, read_n, mode};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic clk_s;
  logic cs_s;
  logic rd_s;
  logic mode_s;
  assign {clk_s, cs_s, rd_s, mode_s} = pin_s2_q;
  logic rd_act;
  assign rd_act = !cs_s && !rd_s;

  // state registers
  abc_state_t  state_q, state_d;
  logic        clk_prev_q, clk_prev_d;
  logic        div_q, div_d;
  logic [1:0]  fall_cnt_q, fall_cnt_d;
  logic [3:0]  cyc_q, cyc_d;
  logic [7:0]  sar_q, sar_d;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  result_q, result_d;
  logic        rd_prev_q, rd_prev_d;
  logic        load_pend_q, load_pend_d;
  logic        blank_q, blank_d;
  logic        sw_q, sw_d;

  logic fall;
  logic int_tick;
  logic rd_start;
  logic cont;
  assign fall     = clk_prev_q && !clk_s;
  assign int_tick = fall && div_q;
  assign rd_start = rd_act && !rd_prev_q;
  assign cont     = MULTI_SAMPLE && !mode_s;

  // next-state logic
  always_comb begin
    state_d     = state_q;
    clk_prev_d  = clk_s;
    div_d       = div_q;
    fall_cnt_d  = fall_cnt_q;
    cyc_d       = cyc_q;
    sar_d       = sar_q;
    bit_d       = bit_q;
    result_d    = result_q;
    rd_prev_d   = rd_act;
    load_pend_d = load_pend_q;
    blank_d     = blank_q;
    sw_d        = sw_q;
    // clock edge within one clock after busy rise ends blank window
    if (fall && blank_q) begin
      blank_d = 1'b0;
    end
    // deferred continuous load once a strobe returns high
    if (load_pend_q && !rd_act) begin
      result_d    = sar_q;
      load_pend_d = 1'b0;
    end
    case (state_q)
      ABC_IDLE: begin
        sw_d = 1'b1;
        if (cont || (rd_start && !blank_q)) begin
          state_d    = ABC_TRACK;
          fall_cnt_d = '0;
          div_d      = 1'b0;
          blank_d    = 1'b0;
        end
      end
      ABC_TRACK: begin
        if (fall) begin
          fall_cnt_d = fall_cnt_q + 2'd1;
          if (fall_cnt_q == 2'(HOLD_EDGE - 1)) begin
            sw_d   = 1'b0;
            state_d = ABC_CONV;
            sar_d  = SAR_MID;
            bit_d  = 3'd7;
            cyc_d  = '0;
            div_d  = 1'b0;
          end
        end
      end
      ABC_CONV: begin
        if (fall) begin
          div_d = !div_q;
          // multi-sample: track through the second half of each decision cycle
          if (MULTI_SAMPLE && !div_q && cyc_q < 4'(NUM_BITS)) begin
            sw_d = 1'b1;
          end
        end
        if (int_tick) begin
          cyc_d = cyc_q + 4'd1;
          if (cyc_q < 4'(NUM_BITS)) begin
            // open the switch, keep or drop the trial bit
            sw_d = 1'b0;
            if (!comp_high) begin
              sar_d[bit_q] = 1'b0;
            end
            if (bit_q != 3'd0) begin
              sar_d[bit_q - 3'd1] = 1'b1;
            end
            bit_d = bit_q - 3'd1;
          end else if (cyc_q == 4'(CONV_INT_CYCLES - 1)) begin
            sw_d = 1'b1;
            if (cont && rd_act) begin
              load_pend_d = 1'b1;
              state_d     = ABC_STALL;
            end else begin
              result_d = sar_q;
              state_d  = ABC_IDLE;
              blank_d  = !cont;
            end
          end
        end
      end
      ABC_STALL: begin
        if (!rd_act) begin
          state_d = ABC_IDLE;
        end
      end
      default: state_d = ABC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q     <= ABC_IDLE;
      clk_prev_q  <= 1'b1;
      div_q       <= 1'b0;
      fall_cnt_q  <= '0;
      cyc_q       <= '0;
      sar_q       <= SAR_MID;
      bit_q       <= 3'd7;
      result_q    <= RESULT_RST;
      rd_prev_q   <= 1'b0;
      load_pend_q <= 1'b0;
      blank_q     <= 1'b0;
      sw_q        <= 1'b1;
    end else begin
      state_q     <= state_d;
      clk_prev_q  <= clk_prev_d;
      div_q       <= div_d;
      fall_cnt_q  <= fall_cnt_d;
      cyc_q       <= cyc_d;
      sar_q       <= sar_d;
      bit_q       <= bit_d;
      result_q    <= result_d;
      rd_prev_q   <= rd_prev_d;
      load_pend_q <= load_pend_d;
      blank_q     <= blank_d;
      sw_q        <= sw_d;
    end
  end

  // outputs
  assign busy_n        = !(state_q == ABC_TRACK || state_q == ABC_CONV);
  assign data_out      = result_q;
  assign data_oe_n     = {8{!rd_act}};
  assign sample_switch = sw_q;
  assign dac_code      = sar_q;

  // checks
  property p_busy_on_start;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (state_q == ABC_IDLE && rd_start && !blank_q && !cont) |=> !busy_n;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("busy not low after start");

  property p_hold_open;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (state_q == ABC_TRACK && fall && fall_cnt_q == 2'd2) |=> !sample_switch;
  endproperty
  a_hold_open: assert property (p_hold_open) else $error("switch not opened at hold");

  property p_track_at_start;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      $fell(busy_n) |-> sample_switch;
  endproperty
  a_track_at_start: assert property (p_track_at_start) else $error("switch open at start");

  property p_track_hold;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (state_q == ABC_TRACK) |-> sample_switch;
  endproperty
  a_track_hold: assert property (p_track_hold) else $error("switch open while tracking");

  property p_track_after_end;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      $rose(busy_n) |-> sample_switch;
  endproperty
  a_track_after_end: assert property (p_track_after_end) else $error("switch not closed at end");

  property p_conv_len;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (state_q == ABC_CONV) |-> (cyc_q < 4'(CONV_INT_CYCLES));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion longer than ten cycles");

  property p_no_self_start;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (state_q == ABC_IDLE && !cont && !rd_start) |=> busy_n;
  endproperty
  a_no_self_start: assert property (p_no_self_start) else $error("conversion started without read");

  property p_result_on_end;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      ($rose(busy_n) && $past(state_q) == ABC_CONV && !load_pend_q) |-> result_q == $past(sar_q);
  endproperty
  a_result_on_end: assert property (p_result_on_end) else $error("result not loaded at end");

  property p_data_stable;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (!busy_n && $past(!busy_n)) |-> $stable(data_out);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data changed mid conversion");

  property p_oe;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      data_oe_n == {8{$past(chip_sel_n, 2) || $past(read_n, 2)}};
  endproperty
  a_oe: assert property (p_oe) else $error("output enable mismatch");

  property p_stall;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (state_q == ABC_STALL && rd_act) |=> busy_n && state_q == ABC_STALL;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not held");

  property p_blank;
    @(posedge ref_clk) disable iff (!rst_sync_n)
      (blank_q && state_q == ABC_IDLE && !cont) |=> busy_n;
  endproperty
  a_blank: assert property (p_blank) else $error("conversion started in blank window");

  c_start: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) $fell(busy_n));
  c_end:   cover property (@(posedge ref_clk) disable iff (!rst_sync_n) $rose(busy_n));
  c_stall: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) state_q == ABC_STALL);
  c_blank: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) blank_q && rd_start);

endmodule : abc_conv_ctrl
`default_nettype wire

/* File: logic/abc_pkg.sv */
package abc_pkg;
  // conversion timing in pin clock cycles and divided (internal) clock cycles
  localparam int unsigned CONV_IN_CYCLES  = 20;                 // pin clock cycles per conversion
  localparam int unsigned CLK_DIV         = 2;                  // pin clock divided by two
  localparam int unsigned CONV_INT_CYCLES = CONV_IN_CYCLES / CLK_DIV;
  localparam int unsigned HOLD_EDGE       = 3;                  // falling edges to hold instant
  localparam int unsigned NUM_BITS        = 8;                  // result width / sample count
  localparam logic [7:0]  RESULT_RST      = 8'h00;
  localparam logic [7:0]  SAR_MID         = 8'h80;              // dac starts at half scale

  // converter state, one-hot
  typedef enum logic [3:0] {
    ABC_IDLE  = 4'b0001,
    ABC_TRACK = 4'b0010,
    ABC_CONV  = 4'b0100,
    ABC_STALL = 4'b1000
  } abc_state_t;
endpackage : abc_pkg

/* File: tb/abc_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module abc_analog_model
  import abc_pkg::*;
(
  input  wire logic [7:0] ain_code,
  input  wire logic [7:0] dac_code,
  output logic            comp_high
);
  // input sits half a step above its code, so a tie decides high
  assign comp_high = (ain_code >= dac_code);
endmodule : abc_analog_model
`default_nettype wire

/* File: tb/test_adc_bus_conversion_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_adc_bus_conversion_control;
  import abc_pkg::*;
  logic       ref_clk, rst_n, conv_clk, chip_sel_n, read_n, mode, comp_high;
  logic       busy_n, sample_switch, busy_d;
  logic [7:0] data_out, data_oe_n, dac_code, ain_code, prev, a;
  logic [7:0] exp_q[$];
  int         num_errors, check_count, cyc, fall_cnt, n;

  abc_conv_ctrl #(.MULTI_SAMPLE(1'b0)) abc_conv_ctrl_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .conv_clk(conv_clk), .chip_sel_n(chip_sel_n),
    .read_n(read_n), .mode(mode), .comp_high(comp_high), .busy_n(busy_n),
    .data_out(data_out), .data_oe_n(data_oe_n), .sample_switch(sample_switch), .dac_code(dac_code));
  abc_analog_model abc_analog_model_i (.ain_code(ain_code), .dac_code(dac_code), .comp_high(comp_high));

  // system clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // pin clock at one eighth of the system clock, plus hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) conv_clk <= ~conv_clk;
    if (cyc > 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // falling pin clock edges
  always @(negedge conv_clk) fall_cnt++;

  task automatic check_eq(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check_eq

  // result monitor: takes the oldest note at every end of conversion
  always @(posedge ref_clk) begin
    busy_d <= busy_n;
    if (rst_n === 1'b1 && busy_n === 1'b1 && busy_d === 1'b0) begin
      check_eq({7'h00, sample_switch}, 8'h01, "tracking after end");
      if (exp_q.size() == 0) check_eq(8'h00, 8'h01, "no result expected");
      else check_eq(data_out, exp_q.pop_front(), "result");
    end
  end

  // one conversion; slow keeps strobes low until busy returns high
  task automatic convert(input bit slow, input logic [7:0] ain, input logic [7:0] old);
    int f0, k, d;
    @(negedge conv_clk);
    @(posedge conv_clk);
    @(posedge ref_clk);
    ain_code <= ain;
    chip_sel_n <= 1'b0;
    read_n <= 1'b0;
    f0 = fall_cnt;
    exp_q.push_back(ain);
    repeat (6) @(posedge ref_clk);
    check_eq(data_oe_n, 8'h00, "bus driven in read");
    check_eq({7'h00, busy_n}, 8'h00, "busy low");
    check_eq({7'h00, sample_switch}, 8'h01, "tracking at start");
    if (!slow) begin
      check_eq(data_out, old, "old data");
      chip_sel_n <= 1'b1;
      read_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check_eq(data_oe_n, 8'hff, "bus released");
    end
    k = 0;
    while (sample_switch !== 1'b0 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    check_eq(8'(fall_cnt - f0), 8'(HOLD_EDGE), "hold edge");
    f0 = fall_cnt;
    k = 0;
    while (busy_n !== 1'b1 && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    d = fall_cnt - f0;
    check_eq({7'h00, d >= CONV_IN_CYCLES - 1 && d <= CONV_IN_CYCLES + 1}, 8'h01, "length");
    if (slow) begin
      chip_sel_n <= 1'b1;
      read_n <= 1'b1;
    end
  endtask : convert

  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    chip_sel_n = 1'b1;
    read_n = 1'b1;
    mode = 1'b1;
    rst_n = 1'b0;
    conv_clk = 1'b0;
    ain_code = 8'h00;
    busy_d = 1'b1;
    cyc = 0;
    fall_cnt = 0;
    num_errors = 0;
    check_count = 0;
    prev = RESULT_RST;
    void'($urandom(32'h7c60));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    convert(1'b1, 8'h00, prev);
    convert(1'b1, 8'hff, prev);
    prev = 8'hff;
    for (int i = 0; i < 6; i++) begin
      a = 8'($urandom_range(255));
      convert(1'b0, a, prev);
      prev = a;
      repeat (12) @(posedge ref_clk);
    end
    // read right after the end returns data but starts nothing
    convert(1'b0, 8'h5a, prev);
    chip_sel_n <= 1'b0;
    read_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check_eq(data_out, 8'h5a, "new data");
    chip_sel_n <= 1'b1;
    read_n <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge ref_clk);
      if (busy_n !== 1'b1) n++;
    end
    check_eq(8'(n), 8'h00, "no restart");
    give_verdict();
  end
endmodule : test_adc_bus_conversion_control
`default_nettype wire
